// File: verilog/csf_pkg.sv
// Constants for the converter status flag bank.
// Assumes a 100 MHz aclk and an AXI4-Lite master with 32-bit data.
//
// How it works
// - Status-zero bit 7 is set after a watchdog-forced power-on reset.
// - Status-zero bit 6 is set after disturbed configuration forced a reset.
// - Trigger while processor runs forces initial reset, recorded in status-zero bit 5.
// - Status-zero bit 1 is high while the capacitance converter runs.
// - Status-zero bit 0 mirrors the measurement run bit of configuration register 47.
// - Status-one bit 3 is set on a resistance unit error while the resistance unit is busy.
// - Status-one bit 2 is set on a timing error during capacitance conversion.
// - Status-one bit 1 is set on overflow while the capacitance unit is busy.
// - Status-one bit 0 is the OR of all error flags, port faults included.
// - Status-two bits 0 to 6 port faults, bit 7 zero.
// - A port fault flag rises on short, resistance, capacitance or timing faults.
// - Capacitances and resistances are both measured by timing a discharge.
// - All ports are served in turn by one time-to-digital converter.
// - Status registers sit at read addresses 32 to 34.
package csf_pkg;
    // ------------------------------------------------------------
    // Register map (index times four gives the byte address)
    // ------------------------------------------------------------
    localparam logic [7:0] CSF_IDX_STATUS0 = 8'h20;
    localparam logic [7:0] CSF_IDX_STATUS1 = 8'h21;
    localparam logic [7:0] CSF_IDX_STATUS2 = 8'h22;
    localparam logic [7:0] CSF_IDX_CONFIG47 = 8'h2f;
    localparam logic [7:0] CSF_IDX_IRQ_STAT = 8'h40;
    localparam logic [7:0] CSF_IDX_IRQ_MASK = 8'h41;
    localparam logic [7:0] CSF_IDX_STICKY_CLR = 8'h42;
    localparam int CSF_ADDR_W = 10;
    // ------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------
    localparam int CSF_S0_WDOG = 7;
    localparam int CSF_S0_CFG = 6;
    localparam int CSF_S0_COLL = 5;
    localparam int CSF_S0_BOOT = 4;
    localparam int CSF_S0_RDONE = 2;
    localparam int CSF_S0_CRUN = 1;
    localparam int CSF_S0_RUN = 0;
    localparam int CSF_S1_RERR = 3;
    localparam int CSF_S1_TERR = 2;
    localparam int CSF_S1_OVFL = 1;
    localparam int CSF_S1_COMB = 0;
    localparam int CSF_NPORTS = 7;
    localparam int CSF_NEVT = 13;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CSF_CFG47_RST = 8'h00;
    localparam logic [CSF_NEVT-1:0] CSF_MASK_RST = 13'h0000;
    localparam logic [1:0] CSF_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSF_RESP_SLVERR = 2'h2;
endpackage

// File: verilog/csf_evt_if.sv
// Event bundle between the flag bank and its sticky flag module.
// Assumes a single aclk domain.
`timescale 1ns/1ns
`default_nettype none
interface csf_evt_if
    import csf_pkg::*;
    ();
    logic [CSF_NEVT-1:0] set;
    logic [CSF_NEVT-1:0] clr;
    logic [CSF_NEVT-1:0] flags;
    modport owner (output set, output clr, input flags);
    modport bank (input set, input clr, output flags);
endinterface
`default_nettype wire

// File: verilog/csf_sticky.sv
// Sticky event flags: set wins over clear.
// Assumes synchronous active-low reset on aclk.
`timescale 1ns/1ns
`default_nettype none
module csf_sticky
    import csf_pkg::*;
    #(
    parameter int N = CSF_NEVT
    ) (
    input wire logic aclk,
    input wire logic aresetn,
    csf_evt_if.bank ev
);
    if (N != CSF_NEVT) begin : g_bad_n
        $error("csf_sticky: N must equal CSF_NEVT");
    end
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            logic flag_r;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    flag_r <= 1'b0;
                end else if (ev.set[i]) begin
                    flag_r <= 1'b1;
                end else if (ev.clr[i]) begin
                    flag_r <= 1'b0;
                end
            end
            assign ev.flags[i] = flag_r;
        end
    endgenerate
endmodule
`default_nettype wire

// File: verilog/csf_axil.sv
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes a master that holds valid and payload until taken.
`timescale 1ns/1ns
`default_nettype none
module csf_axil
    import csf_pkg::*;
    (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CSF_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CSF_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [7:0] wr_idx,
    output logic [7:0] wr_byte,
    output logic rd_en,
    output logic [7:0] rd_idx,
    input wire logic [7:0] rd_val,
    input wire logic rd_ok,
    input wire logic wr_ok
);
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] aw_idx_r;
    logic [7:0] w_byte_r;
    logic w_lane_r;
    logic wr_go;

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready = !w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_have_r && w_have_r;
    // Byte lane 0 holds every register; a write without it changes nothing
    assign wr_en = wr_go && w_lane_r;
    assign wr_idx = aw_idx_r;
    assign wr_byte = w_byte_r;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[9:2];

    // ------------------------------------------------------------
    // Write channels, taken in either order
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            aw_idx_r <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_idx_r <= s_axi_awaddr[9:2];
        end else if (wr_go) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CSF_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= CSF_RESP_OKAY;
        end else if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_ok ? CSF_RESP_OKAY : CSF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verilog/csf_top.sv
// Converter status flag bank: reset causes, activity, errors and port faults.
// Assumes event inputs synchronous to aclk, one-cycle pulses or levels as named.
`timescale 1ns/1ns
`default_nettype none
module csf_top
    import csf_pkg::*;
    (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [CSF_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CSF_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wdog_por_evt,
    input wire logic cfg_upset_por_evt,
    input wire logic cap_seq_trigger,
    input wire logic proc_active,
    input wire logic boot_in_progress,
    input wire logic resistance_conv_done,
    input wire logic cap_conv_running,
    input wire logic res_unit_busy,
    input wire logic res_unit_err_evt,
    input wire logic tdc_err_evt,
    input wire logic ovfl_err_evt,
    input wire logic [CSF_NPORTS-1:0] port_fault_evt,
    output logic initial_reset_req,
    output logic measurement_run_copy,
    output logic irq
);
    // ------------------------------------------------------------
    // Sticky event flags
    // ------------------------------------------------------------
    // Order: 0..6 port faults, 7 ovfl, 8 tdc, 9 res err, 10 coll, 11 cfg, 12 wdog
    csf_evt_if ev ();
    csf_sticky #(.N(CSF_NEVT)) u_sticky (
        .aclk(aclk),
        .aresetn(aresetn),
        .ev(ev.bank)
    );

    logic wr_en;
    logic [7:0] wr_idx;
    logic [7:0] wr_byte;
    logic rd_en;
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;
    logic [7:0] cfg47_r;
    logic [CSF_NEVT-1:0] mask_r;
    logic [CSF_NEVT-1:0] irq_stat;
    logic collision;
    logic [7:0] status0;
    logic [7:0] status1;
    logic [7:0] status2;
    logic comb_err;
    logic [CSF_NEVT-1:0] clr_vec;

    // Trigger landing while the processor is busy
    assign collision = cap_seq_trigger && proc_active;

    assign ev.set = {wdog_por_evt,
                     cfg_upset_por_evt,
                     collision,
                     res_unit_err_evt && res_unit_busy,
                     tdc_err_evt && cap_conv_running,
                     ovfl_err_evt && cap_conv_running,
                     port_fault_evt};
    assign ev.clr = clr_vec;
    assign irq_stat = ev.flags;

    // ------------------------------------------------------------
    // Status images
    // ------------------------------------------------------------
    always_comb begin
        status0 = 8'h00;
        status0[CSF_S0_WDOG] = ev.flags[12];
        status0[CSF_S0_CFG] = ev.flags[11];
        status0[CSF_S0_COLL] = ev.flags[10];
        status0[CSF_S0_BOOT] = boot_in_progress;
        status0[CSF_S0_RDONE] = resistance_conv_done;
        status0[CSF_S0_CRUN] = cap_conv_running;
        status0[CSF_S0_RUN] = cfg47_r[0];
    end

    assign comb_err = |ev.flags[9:0];

    always_comb begin
        status1 = 8'h00;
        status1[CSF_S1_RERR] = ev.flags[9];
        status1[CSF_S1_TERR] = ev.flags[8];
        status1[CSF_S1_OVFL] = ev.flags[7];
        status1[CSF_S1_COMB] = comb_err;
    end

    assign status2 = {1'b0, ev.flags[CSF_NPORTS-1:0]};

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    csf_axil u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_byte(wr_byte),
        .rd_en(rd_en),
        .rd_idx(rd_idx),
        .rd_val(rd_val),
        .rd_ok(rd_ok),
        .wr_ok(wr_ok)
    );

    // Status registers are read-only; only control words accept writes
    assign wr_ok = (wr_idx == CSF_IDX_CONFIG47) || (wr_idx == CSF_IDX_IRQ_MASK)
                   || (wr_idx == CSF_IDX_IRQ_STAT) || (wr_idx == CSF_IDX_STICKY_CLR);

    always_comb begin
        rd_val = 8'h00;
        rd_ok = 1'b1;
        if (rd_en) begin
            case (rd_idx)
                CSF_IDX_STATUS0: rd_val = status0;
                CSF_IDX_STATUS1: rd_val = status1;
                CSF_IDX_STATUS2: rd_val = status2;
                CSF_IDX_CONFIG47: rd_val = cfg47_r;
                CSF_IDX_IRQ_STAT: rd_val = irq_stat[7:0];
                CSF_IDX_IRQ_MASK: rd_val = mask_r[7:0];
                CSF_IDX_STICKY_CLR: rd_val = {3'h0, irq_stat[12:8]};
                default: rd_ok = 1'b0;
            endcase
        end
    end

    // Write-one-to-clear; low byte at IRQ_STAT, high bits at STICKY_CLR
    always_comb begin
        clr_vec = '0;
        if (wr_en && wr_idx == CSF_IDX_IRQ_STAT) begin
            clr_vec[7:0] = wr_byte;
        end else if (wr_en && wr_idx == CSF_IDX_STICKY_CLR) begin
            clr_vec[12:8] = wr_byte[4:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg47_r <= CSF_CFG47_RST;
        end else if (wr_en && wr_idx == CSF_IDX_CONFIG47) begin
            cfg47_r <= wr_byte;
        end
    end

    // Mask: low byte plus five upper event bits packed in bits 7:3
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= CSF_MASK_RST;
        end else if (wr_en && wr_idx == CSF_IDX_IRQ_MASK) begin
            mask_r[7:0] <= wr_byte;
            mask_r[12:8] <= wr_byte[7:3];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            initial_reset_req <= 1'b0;
        end else begin
            initial_reset_req <= collision;
        end
    end

    assign measurement_run_copy = cfg47_r[0];
    // A set mask bit keeps its event off the interrupt
    assign irq = |(irq_stat & ~mask_r);

    // Capacitance and resistance units share one discharge-timing TDC,
    // ports served in turn; this bank only sees their results.
endmodule
`default_nettype wire

// File: dv/csf_monitor.sv
// Concurrent checks on the status flag bank top-level ports.
// Assumes binding to csf_top in a single aclk domain.
`timescale 1ns/1ns
`default_nettype none
module csf_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cap_seq_trigger,
    input wire logic proc_active,
    input wire logic initial_reset_req
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_coll_req;
        cap_seq_trigger && proc_active |=> initial_reset_req;
    endproperty
    a_coll_req: assert property (p_coll_req) else $error("no reset request after collision");
    property p_req_cause;
        initial_reset_req |-> $past(cap_seq_trigger) && $past(proc_active);
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("reset request without cause");
    property p_req_pulse;
        initial_reset_req && !(cap_seq_trigger && proc_active) |=> !initial_reset_req;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("reset request too long");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_ar_refuse;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
    property p_aw_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while busy");
    property p_r_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_b_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
    endproperty
    a_b_answer: assert property (p_b_answer) else $error("write answer late");
endmodule
bind csf_top csf_monitor u_mon (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cap_seq_trigger(cap_seq_trigger), .proc_active(proc_active),
    .initial_reset_req(initial_reset_req));
`default_nettype wire

// File: dv/converter_status_flags_tb.sv
// Self-checking bench for the status flag bank.
// Assumes csf_top and its package compiled first.
`timescale 1ns/1ns
`default_nettype none
module converter_status_flags_tb;
    import csf_pkg::*;
    typedef struct packed {
        logic [3:0] lv;
        logic [11:0] pl;
        logic [9:0] ra;
        logic [7:0] ex;
        logic [9:0] ca;
        logic [7:0] cd;
    } csf_row_s;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0, ct = 0, pa = 0;
    logic awr, wr_rdy, arr, req, runc, irq;
    logic [9:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] brs, rrs, rsp;
    logic [11:0] pv = 0;
    logic [3:0] lvv = 0;
    logic [31:0] got;
    csf_row_s rows [11];
    int bad_count = 0, compares = 0;
    always #5 aclk = ~aclk;
    csf_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr), .wdog_por_evt(pv[10]),
        .cfg_upset_por_evt(pv[11]), .cap_seq_trigger(ct), .proc_active(pa),
        .boot_in_progress(lvv[0]), .resistance_conv_done(lvv[1]), .cap_conv_running(lvv[2]),
        .res_unit_busy(lvv[3]), .res_unit_err_evt(pv[9]), .tdc_err_evt(pv[8]),
        .ovfl_err_evt(pv[7]), .port_fault_evt(pv[6:0]), .initial_reset_req(req),
        .measurement_run_copy(runc), .irq(irq));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awv && awr) awv <= 0;
            if (wv && wr_rdy) wv <= 0;
            if (bv) begin
                rsp = brs; br <= 0; break;
            end
        end
        if (n == 50) chk(32'h0, 32'h1);
    endtask
    task automatic rdr(input logic [9:0] a);
        int n;
        @(posedge aclk);
        ara <= a; arv <= 1; rr <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arv && arr) arv <= 0;
            if (rv) begin
                got = rd; rsp = rrs; rr <= 0; break;
            end
        end
        if (n == 50) chk(32'h0, 32'h1);
    endtask
    task automatic pulse(input logic [11:0] p);
        @(posedge aclk);
        pv <= p;
        @(posedge aclk);
        pv <= 0;
        #1;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rows[0] = '{4'h0, 12'h400, 10'h080, 8'h80, 10'h108, 8'h10};
        rows[1] = '{4'h0, 12'h800, 10'h080, 8'h40, 10'h108, 8'h08};
        rows[2] = '{4'h7, 12'h000, 10'h080, 8'h16, 10'h108, 8'h00};
        rows[3] = '{4'h8, 12'h200, 10'h084, 8'h09, 10'h108, 8'h02};
        rows[4] = '{4'h4, 12'h100, 10'h084, 8'h05, 10'h108, 8'h01};
        rows[5] = '{4'h4, 12'h080, 10'h084, 8'h03, 10'h100, 8'h80};
        rows[6] = '{4'h0, 12'h07f, 10'h088, 8'h7f, 10'h108, 8'h00};
        rows[7] = '{4'h0, 12'h000, 10'h084, 8'h01, 10'h100, 8'h7f};
        rows[8] = '{4'h0, 12'h000, 10'h088, 8'h00, 10'h108, 8'h00};
        rows[9] = '{4'h0, 12'h200, 10'h084, 8'h00, 10'h108, 8'h00};
        rows[10] = '{4'h0, 12'h180, 10'h084, 8'h00, 10'h108, 8'h00};
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        chk({31'h0, irq}, 32'h0);
        foreach (rows[i]) begin
            @(posedge aclk);
            lvv <= rows[i].lv;
            pulse(rows[i].pl);
            rdr(rows[i].ra);
            chk(got, {24'h0, rows[i].ex});
            wr(rows[i].ca, {24'h0, rows[i].cd});
            lvv <= 4'h0;
        end
        $display("test rows done");
        @(posedge aclk);
        ct <= 1; pa <= 1;
        @(posedge aclk);
        ct <= 0; pa <= 0;
        #1 chk({31'h0, req}, 32'h1);
        rdr(10'h080);
        chk(got, 32'h20);
        wr(10'h108, 32'h04);
        $display("test collision done");
        wr(10'h0bc, 32'h1);
        chk({31'h0, runc}, 32'h1);
        rdr(10'h080);
        chk(got, 32'h01);
        wr(10'h0bc, 32'h0);
        chk({31'h0, runc}, 32'h0);
        $display("test run copy done");
        wr(10'h080, 32'hff);
        chk({30'h0, rsp}, {30'h0, CSF_RESP_SLVERR});
        rdr(10'h080);
        chk(got, 32'h0);
        rdr(10'h3fc);
        chk({rsp, got[29:0]}, {CSF_RESP_SLVERR, 30'h0});
        $display("test access done");
        pulse(12'h001);
        chk({31'h0, irq}, 32'h1);
        wr(10'h104, 32'h01);
        chk({31'h0, irq}, 32'h0);
        wr(10'h104, 32'h00);
        chk({31'h0, irq}, 32'h1);
        wr(10'h100, 32'h01);
        chk({31'h0, irq}, 32'h0);
        $display("test irq done");
        pulse(12'h040);
        chk({31'h0, irq}, 32'h1);
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        #1 chk({31'h0, irq}, 32'h0);
        rdr(10'h088);
        chk(got, 32'h0);
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
